// ---- design/slice_params.svh ----
`ifndef SLICE_PARAMS_SVH
`define SLICE_PARAMS_SVH

// Slice width and instruction word width
`define SLICE_WIDTH 4
`define INSTR_WIDTH 4

// Instruction field positions
`define INSTR_ROUTE_BIT 0
`define INSTR_SEL_LSB 1
`define INSTR_SEL_MSB 3

// Values held by the working and output registers after reset
`define REG_RESET_VALUE 4'h0
`define OUT_N_RESET_VALUE 4'hf

// Depth of the pin synchroniser
`define SYNC_STAGES 2

`endif

// ---- design/slice_pkg.sv ----
`include "slice_params.svh"

package slice_pkg;

  // Which working register takes part in an operation
  typedef enum logic [1:0] {
    sel_none,
    sel_pc,
    sel_sp,
    sel_oa
  } reg_sel_type;

  // Decoded upper instruction field
  typedef struct packed {
    reg_sel_type operand;
    reg_sel_type dest;
    reg_sel_type view;
  } decode_type;

endpackage

// ---- design/adder_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface adder_if #(
  parameter int W = 4
);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic cin;
  logic [W-1:0] sum;
  logic cout;

  modport user (output a, output b, output cin, input sum, input cout);
  modport core (input a, input b, input cin, output sum, output cout);
endinterface

`default_nettype wire

// ---- design/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

`default_nettype wire

// ---- design/slice_adder.sv ----
`timescale 1ns/100ps
`default_nettype none

module slice_adder #(
  parameter int W = 4
) (
  adder_if.core bus
);
  logic [W:0] total;

  assign total = {1'b0, bus.a} + {1'b0, bus.b} + {{W{1'b0}}, bus.cin};
  assign bus.sum = total[W-1:0];
  assign bus.cout = total[W];
endmodule

`default_nettype wire

// ---- design/address_arith_slice.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "slice_params.svh"

module address_arith_slice #(
  parameter int W = `SLICE_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clock_pin,
  input wire logic run_strobe_n,
  input wire logic [`INSTR_WIDTH-1:0] instruction_bits,
  input wire logic [W-1:0] data_in_n,
  input wire logic carry_in_n,
  input wire logic addr_out_enable_n,
  input wire logic data_out_enable_n,
  output logic [W-1:0] address_bus_out,
  output logic address_bus_oe,
  output logic [W-1:0] data_out_n,
  output logic data_out_oe,
  output logic carry_out_n
);
  import slice_pkg::*;

  localparam int SW = W + `INSTR_WIDTH + 5;

  if (W < 1) begin : g_bad_width
    $error("address_arith_slice: W must be at least 1");
  end

  // Pins arrive from another clock domain
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic cp_s;
  logic ex_n_s;
  logic [`INSTR_WIDTH-1:0] instr_s;
  logic [W-1:0] din_n_s;
  logic cin_n_s;
  logic aoe_n_s;
  logic doe_n_s;

  // The synchroniser clears to zero; pins are stored relative to their idle
  // levels so that reset leaves strobe, clock and enables idle, never active
  localparam logic [SW-1:0] PIN_IDLE = {2'b11, {`INSTR_WIDTH{1'b0}}, {W{1'b0}}, 3'b111};

  assign pins_raw = PIN_IDLE ^ {clock_pin, run_strobe_n, instruction_bits, data_in_n,
                                carry_in_n, addr_out_enable_n, data_out_enable_n};

  pin_sync #(.W(SW)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {cp_s, ex_n_s, instr_s, din_n_s, cin_n_s, aoe_n_s, doe_n_s} = pins_s ^ PIN_IDLE;

  // Instruction decode
  function automatic decode_type decode(input logic [2:0] sel);
    decode_type r;
    r = '{operand: sel_none, dest: sel_none, view: sel_none};
    unique case (sel)
      3'b000: r = '{operand: sel_pc, dest: sel_pc, view: sel_pc};
      3'b001: r = '{operand: sel_pc, dest: sel_sp, view: sel_pc};
      3'b010: r = '{operand: sel_pc, dest: sel_oa, view: sel_pc};
      3'b011: r = '{operand: sel_sp, dest: sel_sp, view: sel_sp};
      3'b100: r = '{operand: sel_none, dest: sel_oa, view: sel_oa};
      3'b101: r = '{operand: sel_none, dest: sel_pc, view: sel_pc};
      3'b110: r = '{operand: sel_oa, dest: sel_oa, view: sel_oa};
      3'b111: r = '{operand: sel_none, dest: sel_sp, view: sel_sp};
    endcase
    return r;
  endfunction

  logic [W-1:0] bank_q [0:2];

  // Register read port, shared by the operand path and the address view
  function automatic logic [W-1:0] pick(input reg_sel_type s,
                                        input logic [W-1:0] pc,
                                        input logic [W-1:0] sp,
                                        input logic [W-1:0] oa);
    logic [W-1:0] v;
    v = '0;
    unique case (s)
      sel_none: v = '0;
      sel_pc: v = pc;
      sel_sp: v = sp;
      sel_oa: v = oa;
    endcase
    return v;
  endfunction

  decode_type dec;
  logic [W-1:0] operand_reg;
  logic [W-1:0] view_reg;
  logic [W-1:0] din;
  logic cin;
  logic route_sum;

  assign dec = decode(instr_s[`INSTR_SEL_MSB:`INSTR_SEL_LSB]);
  assign operand_reg = pick(dec.operand, bank_q[0], bank_q[1], bank_q[2]);
  assign view_reg = pick(dec.view, bank_q[0], bank_q[1], bank_q[2]);
  assign din = ~din_n_s;
  assign cin = ~cin_n_s;
  assign route_sum = instr_s[`INSTR_ROUTE_BIT];

  // Adder: data word plus selected register plus carry
  adder_if #(.W(W)) add_bus ();
  assign add_bus.a = din;
  assign add_bus.b = operand_reg;
  assign add_bus.cin = cin;

  slice_adder #(.W(W)) u_adder (
    .bus(add_bus)
  );

  // Gated internal clock: high while either the clock pin or the strobe is high.
  // Only a rise caused by the clock pin with the strobe low writes; a strobe
  // rise while the clock pin is low is ignored instead of making a false edge.
  logic iclk;
  logic iclk_q;
  logic write_en;

  assign iclk = cp_s | ex_n_s;
  assign write_en = iclk & ~iclk_q & ~ex_n_s;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      iclk_q <= 1'b1;
    end else begin
      iclk_q <= iclk;
    end
  end

  // Working registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int k = 0; k < 3; k++) begin
        bank_q[k] <= `REG_RESET_VALUE;
      end
    end else if (write_en) begin
      for (int k = 0; k < 3; k++) begin
        if (int'(dec.dest) == k + 1) begin
          bank_q[k] <= add_bus.sum;
        end
      end
    end
  end

  // Output register, kept in pin polarity so the pins come straight from it
  logic [W-1:0] out_n_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      out_n_q <= `OUT_N_RESET_VALUE;
    end else if (write_en) begin
      out_n_q <= ~add_bus.sum;
    end
  end

  // Pin registers. The address mux is combinational in the part; here it
  // costs one mclk of latency so that every pin comes from a flip-flop.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      address_bus_out <= '0;
      address_bus_oe <= 1'b0;
      data_out_oe <= 1'b0;
      carry_out_n <= 1'b1;
    end else begin
      address_bus_out <= route_sum ? add_bus.sum : view_reg;
      address_bus_oe <= ~aoe_n_s;
      data_out_oe <= ~doe_n_s;
      carry_out_n <= ~add_bus.cout;
    end
  end

  assign data_out_n = out_n_q;

  // Checks
  logic [W:0] dpc_full;
  logic [W-1:0] d_plus_c;

  assign dpc_full = {1'b0, din} + {{W{1'b0}}, cin};
  assign d_plus_c = dpc_full[W-1:0];

  property p_pc_self;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s == 4'h0) |=>
        (bank_q[0] == $past(add_bus.sum)) && (data_out_n == ~$past(add_bus.sum));
  endproperty
  a_pc_self: assert property (p_pc_self) else $error("pc update wrong");

  property p_data_to_oa;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s[3:1] == 3'b100) |=> (bank_q[2] == $past(d_plus_c));
  endproperty
  a_data_to_oa: assert property (p_data_to_oa) else $error("data plus carry lost");

  property p_no_write_idle;
    @(posedge mclk) disable iff (!rst_b)
      !write_en |=> ($stable(bank_q[0]) && $stable(bank_q[1]) && $stable(bank_q[2]));
  endproperty
  a_no_write_idle: assert property (p_no_write_idle) else $error("write without edge");

  property p_strobe_high_holds;
    @(posedge mclk) disable iff (!rst_b)
      ex_n_s |=> ($stable(data_out_n) && $stable(bank_q[1]));
  endproperty
  a_strobe_high_holds: assert property (p_strobe_high_holds) else $error("write with strobe high");

  property p_route_sum;
    @(posedge mclk) disable iff (!rst_b)
      route_sum |=> (address_bus_out == $past(add_bus.sum));
  endproperty
  a_route_sum: assert property (p_route_sum) else $error("address not adder result");

  property p_view_sp;
    @(posedge mclk) disable iff (!rst_b)
      (!route_sum && instr_s[3:1] == 3'b011) |=> (address_bus_out == $past(bank_q[1]));
  endproperty
  a_view_sp: assert property (p_view_sp) else $error("address view wrong");

  property p_addr_oe;
    @(posedge mclk) disable iff (!rst_b)
      aoe_n_s |=> !address_bus_oe;
  endproperty
  a_addr_oe: assert property (p_addr_oe) else $error("address driven while disabled");

  property p_data_oe;
    @(posedge mclk) disable iff (!rst_b)
      (!doe_n_s ##1 !doe_n_s) |-> data_out_oe;
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data not driven");

  property p_carry_chain;
    @(posedge mclk) disable iff (!rst_b)
      (instr_s[3:1] == 3'b100 && din_n_s == '0 && !cin_n_s) |=> !carry_out_n;
  endproperty
  a_carry_chain: assert property (p_carry_chain) else $error("carry out missing");

  property p_din_polarity;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s[3:1] == 3'b101 && cin_n_s) |=> (data_out_n == $past(din_n_s));
  endproperty
  a_din_polarity: assert property (p_din_polarity) else $error("data polarity wrong");

  property p_pc_to_sp;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s[3:1] == 3'b001) |=> (bank_q[1] == $past(bank_q[0] + d_plus_c));
  endproperty
  a_pc_to_sp: assert property (p_pc_to_sp) else $error("sp load wrong");

  property p_pc_to_oa;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s[3:1] == 3'b010) |=> (bank_q[2] == $past(bank_q[0] + d_plus_c));
  endproperty
  a_pc_to_oa: assert property (p_pc_to_oa) else $error("oa load wrong");

  property p_sp_self;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s[3:1] == 3'b011) |=> (bank_q[1] == $past(bank_q[1] + d_plus_c));
  endproperty
  a_sp_self: assert property (p_sp_self) else $error("sp update wrong");

  property p_oa_self;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s[3:1] == 3'b110) |=> (bank_q[2] == $past(bank_q[2] + d_plus_c));
  endproperty
  a_oa_self: assert property (p_oa_self) else $error("oa update wrong");

  property p_data_to_sp;
    @(posedge mclk) disable iff (!rst_b)
      (write_en && instr_s[3:1] == 3'b111) |=> (bank_q[1] == $past(d_plus_c));
  endproperty
  a_data_to_sp: assert property (p_data_to_sp) else $error("sp data load wrong");

  property p_out_hold;
    @(posedge mclk) disable iff (!rst_b)
      !write_en |=> $stable(data_out_n);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output register moved");

  property p_real_edge;
    @(posedge mclk) disable iff (!rst_b)
      (cp_s && !ex_n_s && !$past(cp_s) && !$past(ex_n_s)) |-> write_en;
  endproperty
  a_real_edge: assert property (p_real_edge) else $error("clock edge lost");

  property p_view_pc;
    @(posedge mclk) disable iff (!rst_b)
      (!route_sum && instr_s[3:1] == 3'b000) |=> (address_bus_out == $past(bank_q[0]));
  endproperty
  a_view_pc: assert property (p_view_pc) else $error("pc not on address");

endmodule

`default_nettype wire

// ---- tb/bus_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module bus_model #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic [W-1:0] drive,
  input wire logic oe,
  output logic [W-1:0] bus_level
);
  logic [W-1:0] last_q = '0;

  always_ff @(posedge mclk) begin
    if (oe) begin
      last_q <= drive;
    end
  end

  // A released bus shows the inverse of its last value, so a stale level never passes
  assign bus_level = oe ? drive : ~last_q;
endmodule

`default_nettype wire

// ---- tb/address_arith_slice_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module address_arith_slice_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic clock_pin = 1'b1;
  logic run_strobe_n = 1'b1;
  logic [3:0] instruction_bits = 4'h0;
  logic [3:0] data_in_n = 4'hf;
  logic carry_in_n = 1'b1;
  logic addr_out_enable_n = 1'b1;
  logic data_out_enable_n = 1'b1;
  logic [3:0] address_bus_out, data_out_n, addr_level, data_level;
  logic address_bus_oe, data_out_oe, carry_out_n;
  int num_errors = 0;
  int n_checks = 0;
  logic [10:0] notes [$];
  // Index 3 stands for no register and always reads zero
  logic [3:0] rg [4] = '{default: 4'h0};
  logic [3:0] out_q = 4'h0;
  int op_t [8] = '{0, 0, 0, 1, 3, 3, 2, 3};
  int dst_t [8] = '{0, 1, 2, 1, 2, 0, 2, 1};
  int vw_t [8] = '{0, 0, 0, 1, 2, 0, 2, 1};
  event take;

  address_arith_slice DUT (
    .mclk(mclk),
    .rst_b(rst_b),
    .clock_pin(clock_pin),
    .run_strobe_n(run_strobe_n),
    .instruction_bits(instruction_bits),
    .data_in_n(data_in_n),
    .carry_in_n(carry_in_n),
    .addr_out_enable_n(addr_out_enable_n),
    .data_out_enable_n(data_out_enable_n),
    .address_bus_out(address_bus_out),
    .address_bus_oe(address_bus_oe),
    .data_out_n(data_out_n),
    .data_out_oe(data_out_oe),
    .carry_out_n(carry_out_n)
  );

  bus_model addr_bus (
    .mclk(mclk),
    .drive(address_bus_out),
    .oe(address_bus_oe),
    .bus_level(addr_level)
  );

  bus_model data_bus (
    .mclk(mclk),
    .drive(data_out_n),
    .oe(data_out_oe),
    .bus_level(data_level)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Active-low data and carry are inverted before the add
  function automatic logic [4:0] sum(input int sel);
    return {1'b0, rg[sel]} + {1'b0, ~data_in_n} + {4'h0, ~carry_in_n};
  endfunction

  task automatic note();
    logic [4:0] s;
    s = sum(op_t[instruction_bits[3:1]]);
    notes.push_back({instruction_bits[0] ? s[3:0] : rg[vw_t[instruction_bits[3:1]]],
      ~out_q, ~s[4], ~addr_out_enable_n, ~data_out_enable_n});
    -> take;
  endtask

  task automatic op(input logic [3:0] i, input logic ex, input logic full);
    logic [4:0] s;
    @(posedge mclk);
    #1;
    run_strobe_n = 1'b1;
    instruction_bits = i;
    // A full operand with carry in pushes a carry out of the slice
    data_in_n = full ? 4'h0 : 4'($urandom);
    carry_in_n = full ? 1'b0 : 1'($urandom);
    addr_out_enable_n = 1'($urandom);
    data_out_enable_n = 1'($urandom);
    repeat (4) @(posedge mclk);
    #1;
    run_strobe_n = ex;
    repeat (4) @(posedge mclk);
    #1;
    clock_pin = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    clock_pin = 1'b1;
    s = sum(op_t[i[3:1]]);
    if (!ex) begin
      rg[dst_t[i[3:1]]] = s[3:0];
      out_q = s[3:0];
    end
    repeat (6) @(posedge mclk);
    #1;
    note();
  endtask

  always @(take) begin
    logic [10:0] w;
    w = notes.pop_front();
    check(address_bus_out, w[10:7]);
    check(data_out_n, w[6:3]);
    check({3'h0, carry_out_n}, {3'h0, w[2]});
    check({3'h0, address_bus_oe}, {3'h0, w[1]});
    check({3'h0, data_out_oe}, {3'h0, w[0]});
    if (w[1]) begin
      check(addr_level, w[10:7]);
    end
    if (w[0]) begin
      check(data_level, w[6:3]);
    end
  end

  initial begin
    void'($urandom(23819));
    repeat (4) @(posedge mclk);
    #1;
    note();
    @(posedge mclk);
    #1;
    rst_b = 1'b1;
    // Every code twice, then alternate refused cycles, then a random stream
    for (int k = 0; k < 48; k++) begin
      op(4'(k), 1'(k >= 32 && k[0]), 1'(k == 8 || k == 9));
    end
    for (int k = 0; k < 16; k++) begin
      op(4'($urandom), 1'b0, 1'b0);
    end
    // Let the checker take the last note before the run ends
    @(posedge mclk);
    wrap_up();
  end

  // Budget is about sixteen times the expected run length
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
